// [inc/write_latch_pkg.sv]
// Constants and types for the write latch and register command logic
package write_latch_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [4:0][7:0] reg_bank_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RECEIVE, ST_SEND} frame_state_t;

  localparam byte_t SET_WRITE_LATCH_CMD = 8'h06;
  localparam byte_t CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam byte_t STATUS_WRITE_CMD = 8'h01;
  localparam byte_t STATUS_ONE_READ_CMD = 8'h05;
  localparam byte_t STATUS_TWO_READ_CMD = 8'h07;
  localparam byte_t CONFIG_ONE_READ_CMD = 8'h35;
  localparam byte_t CONFIG_TWO_READ_CMD = 8'h3f;
  localparam byte_t CONFIG_FOUR_READ_CMD = 8'h45;
  localparam byte_t CONFIG_FIVE_READ_CMD = 8'h5e;
  localparam byte_t GENERIC_REG_WRITE_CMD = 8'h71;
  localparam byte_t GENERIC_REG_READ_CMD = 8'h65;

  // Status register one fields
  localparam int WRITE_IN_PROGRESS_BIT = 0;
  localparam int WRITE_ENABLE_LATCH_BIT = 1;
  localparam int STATUS_WRITE_DISABLE_BIT = 7;
  localparam byte_t SR1_STORED_MASK = 8'hfc;
  // Status register two fields
  localparam int CRC_SUSPEND_FLAG_BIT = 0;
  localparam int CRC_ABORT_FLAG_BIT = 1;
  // Latency code in config register five
  localparam int REG_LATENCY_CODE_LSB_BIT = 0;
  localparam int REG_LATENCY_CODE_MSB_BIT = 1;
  localparam logic [5:0] LATENCY_BASE = 6'h00;

  // Generic register address: bank byte, zero middle byte, index byte
  localparam byte_t VOL_BANK = 8'h07;
  localparam byte_t NV_BANK = 8'h00;
  localparam byte_t ADDR_MID = 8'h00;
  localparam byte_t ADDR_SR1 = 8'h00;
  localparam byte_t ADDR_SR2 = 8'h01;
  localparam byte_t ADDR_CR1 = 8'h02;
  localparam byte_t ADDR_CR2 = 8'h03;
  localparam byte_t ADDR_CR4 = 8'h05;
  localparam byte_t ADDR_CR5 = 8'h06;

  // Slots of the register banks; SR2 has no storage
  localparam logic [2:0] IDX_SR1 = 3'h0;
  localparam logic [2:0] IDX_CR1 = 3'h1;
  localparam logic [2:0] IDX_CR2 = 3'h2;
  localparam logic [2:0] IDX_CR4 = 3'h3;
  localparam logic [2:0] IDX_CR5 = 3'h4;
  localparam logic [2:0] IDX_SR2 = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // Factory values of the stored copies, slot 4 down to slot 0
  localparam reg_bank_t NV_DEFAULTS = 40'h00_00_00_00_00;

  // Serial clock edges at which fields complete
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] SR_DATA_END_BITS = 6'h10;
  localparam logic [5:0] ADDR_END_BITS = 6'h20;
  localparam logic [5:0] ANY_DATA_END_BITS = 6'h28;
  localparam logic [5:0] CNT_MAX = 6'h3f;

  // Pin synchroniser reset: wp_b, si, cs_b, sck
  localparam logic [3:0] PIN_SYNC_RESET = 4'ha;
endpackage

// [core/write_latch_cmd_ctrl.sv]
// Serial command logic for the write enable latch and register access
//
// Function
// - Set-latch opcode sets the write enable latch
// - Clear-latch opcode clears the write enable latch
// - Writes refused while the latch is clear
// - Latch set only at select rise, full opcode
// - Latch cleared only at select rise, full opcode, or by reset
// - Clear-latch ignored while write in progress
// - Status write programs stored status register one
// - Status write ignored if locked and protect low
// - Status write needs the latch set
// - Status write end clears the latch
// - Status one read returns protection, latch, busy
// - Register reads return the live copy
// - Read dummy cycles follow the latency code
// - Status two read-only, returns CRC flags
// - Status two valid only when not busy
// - Config one, two, four, five read opcodes
// - Generic write with three-byte register address
// - Generic read with three-byte register address
// - Reset reloads live copies from stored values
// - Generic write locked like status write, clears latch
`timescale 1ns/1ps
module write_latch_cmd_ctrl (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic POR_B_I,
  input wire logic SCK_I,
  input wire logic CS_B_I,
  input wire logic SI_I,
  input wire logic WP_B_I,
  input wire logic WIP_I,
  input wire logic CRC_SUSPEND_I,
  input wire logic CRC_ABORT_I,
  output logic SO_O,
  output logic SO_OE_B_O,
  output logic WEL_O,
  output write_latch_pkg::byte_t SR1_O,
  output write_latch_pkg::byte_t CR1_O,
  output write_latch_pkg::byte_t CR2_O,
  output write_latch_pkg::byte_t CR4_O,
  output write_latch_pkg::byte_t CR5_O
);
  import write_latch_pkg::*;

  logic rst_any;
  logic [3:0] pin_raw, pin_next;
  logic [3:0] sync1_reg, sync2_reg, sync3_reg, pin_reg, prev_reg;
  logic sck_rise, sck_fall, cs_rise, in_frame, si_bit, locked;
  assign rst_any = !RST_B_I || !POR_B_I;
  assign pin_raw = {WP_B_I, SI_I, CS_B_I, SCK_I};
  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level counts once stages two and three agree
  genvar g;
  for (g = 0; g < 4; g++) begin : g_sync
    assign pin_next[g] = (sync2_reg[g] == sync3_reg[g]) ? sync3_reg[g] : pin_reg[g];
  end
  always_ff @(posedge CLK_I) begin
    if (rst_any) begin
      sync1_reg <= PIN_SYNC_RESET;
      sync2_reg <= PIN_SYNC_RESET;
      sync3_reg <= PIN_SYNC_RESET;
      pin_reg <= PIN_SYNC_RESET;
      prev_reg <= PIN_SYNC_RESET;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg <= pin_next;
      prev_reg <= pin_reg;
    end
  end
  assign sck_rise = pin_reg[0] && !prev_reg[0];
  assign sck_fall = !pin_reg[0] && prev_reg[0];
  assign cs_rise = pin_reg[1] && !prev_reg[1];
  assign in_frame = !pin_reg[1];
  assign si_bit = pin_reg[2];

  ////////////////////////////////////////////////////////////////////
  // Register banks
  reg_bank_t vol_reg, vol_next, nv_reg, nv_next;
  logic wel_reg, wel_next;
  // Protection lock applies only while the protect pin is low
  assign locked = vol_reg[IDX_SR1][STATUS_WRITE_DISABLE_BIT] && !pin_reg[3];
  function automatic logic [2:0] reg_index(input byte_t a);
    case (a)
      ADDR_SR1: reg_index = IDX_SR1;
      ADDR_SR2: reg_index = IDX_SR2;
      ADDR_CR1: reg_index = IDX_CR1;
      ADDR_CR2: reg_index = IDX_CR2;
      ADDR_CR4: reg_index = IDX_CR4;
      ADDR_CR5: reg_index = IDX_CR5;
      default: reg_index = IDX_NONE;
    endcase
  endfunction
  function automatic logic bank_ok(input logic [23:0] a);
    bank_ok = (a[23:16] == VOL_BANK || a[23:16] == NV_BANK) && a[15:8] == ADDR_MID;
  endfunction
  ////////////////////////////////////////////////////////////////////
  // Frame capture and serial output
  frame_state_t state_reg, state_next;
  logic [5:0] cnt_reg, cnt_next, cnt_inc, start_cnt;
  logic [31:0] sh_reg, sh_next, sh_shift;
  byte_t op_reg, op_next, op_eff, data_reg, data_next;
  byte_t out_reg, out_next, read_byte, sr2_byte;
  logic [23:0] addr_reg, addr_next, addr_eff;
  logic so_reg, so_next, oe_b_reg, oe_b_next, is_read;
  logic [2:0] read_idx, wr_idx;
  logic [5:0] data_end;
  // Fields as they stand after the current rising edge
  always_comb begin
    cnt_inc = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 6'h01;
    sh_shift = {sh_reg[30:0], si_bit};
    op_eff = (sck_rise && cnt_inc == OPCODE_BITS) ? sh_shift[7:0] : op_reg;
    addr_eff = (sck_rise && cnt_inc == ADDR_END_BITS) ? sh_shift[23:0] : addr_reg;
  end
  // Flags may be stale while busy; they pass through unfiltered
  always_comb begin
    sr2_byte = 8'h00;
    sr2_byte[CRC_SUSPEND_FLAG_BIT] = CRC_SUSPEND_I;
    sr2_byte[CRC_ABORT_FLAG_BIT] = CRC_ABORT_I;
  end
  always_comb begin
    is_read = 1'b1;
    read_idx = IDX_NONE;
    case (op_eff)
      STATUS_ONE_READ_CMD: read_idx = IDX_SR1;
      STATUS_TWO_READ_CMD: read_idx = IDX_SR2;
      CONFIG_ONE_READ_CMD: read_idx = IDX_CR1;
      CONFIG_TWO_READ_CMD: read_idx = IDX_CR2;
      CONFIG_FOUR_READ_CMD: read_idx = IDX_CR4;
      CONFIG_FIVE_READ_CMD: read_idx = IDX_CR5;
      GENERIC_REG_READ_CMD: begin
        if (bank_ok(addr_eff)) begin
          read_idx = reg_index(addr_eff[7:0]);
        end
      end
      default: is_read = 1'b0;
    endcase
    // Both bank addresses return the live copy
    read_byte = 8'h00;
    case (read_idx)
      IDX_SR1: begin
        read_byte = vol_reg[IDX_SR1] & SR1_STORED_MASK;
        read_byte[WRITE_ENABLE_LATCH_BIT] = wel_reg;
        read_byte[WRITE_IN_PROGRESS_BIT] = WIP_I;
      end
      IDX_SR2: read_byte = sr2_byte;
      IDX_CR1: read_byte = vol_reg[IDX_CR1];
      IDX_CR2: read_byte = vol_reg[IDX_CR2];
      IDX_CR4: read_byte = vol_reg[IDX_CR4];
      IDX_CR5: read_byte = vol_reg[IDX_CR5];
      default: read_byte = 8'h00;
    endcase
  end
  // Data starts on the falling edge after the last dummy bit
  always_comb begin
    start_cnt = ((op_eff == GENERIC_REG_READ_CMD) ? ADDR_END_BITS : OPCODE_BITS)
      + LATENCY_BASE
      + {4'h0, vol_reg[IDX_CR5][REG_LATENCY_CODE_MSB_BIT:REG_LATENCY_CODE_LSB_BIT]};
    case (op_eff)
      STATUS_WRITE_CMD: data_end = SR_DATA_END_BITS;
      GENERIC_REG_WRITE_CMD: data_end = ANY_DATA_END_BITS;
      default: data_end = CNT_MAX;
    endcase
  end
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    out_next = out_reg;
    so_next = so_reg;
    oe_b_next = oe_b_reg;
    if (!in_frame) begin
      state_next = ST_IDLE;
      cnt_next = 6'h00;
      so_next = 1'b0;
      oe_b_next = 1'b1;
    end else begin
      if (sck_rise) begin
        cnt_next = cnt_inc;
        sh_next = sh_shift;
        op_next = op_eff;
        addr_next = addr_eff;
        if (cnt_inc == data_end) begin
          data_next = sh_shift[7:0];
        end
        if (is_read && cnt_inc == start_cnt) begin
          state_next = ST_SEND;
          out_next = read_byte;
        end
      end
      case (state_reg)
        ST_IDLE: state_next = ST_RECEIVE;
        ST_RECEIVE: ;
        ST_SEND: begin
          // Byte repeats for as long as the host keeps clocking
          if (sck_fall) begin
            so_next = out_reg[7];
            oe_b_next = 1'b0;
            out_next = {out_reg[6:0], out_reg[7]};
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
    if (rst_any) begin
      state_next = ST_IDLE;
      cnt_next = 6'h00;
      op_next = 8'h00;
      so_next = 1'b0;
      oe_b_next = 1'b1;
    end
  end
  always_ff @(posedge CLK_I) begin
    state_reg <= state_next;
    cnt_reg <= cnt_next;
    sh_reg <= sh_next;
    op_reg <= op_next;
    addr_reg <= addr_next;
    data_reg <= data_next;
    out_reg <= out_next;
    so_reg <= so_next;
    oe_b_reg <= oe_b_next;
  end

  ////////////////////////////////////////////////////////////////////
  // Commands act at select rise, from what was captured
  assign wr_idx = reg_index(addr_reg[7:0]);
  always_comb begin
    wel_next = wel_reg;
    vol_next = vol_reg;
    nv_next = nv_reg;
    // Fewer than eight bits: nothing happens
    if (cs_rise && cnt_reg >= OPCODE_BITS) begin
      case (op_reg)
        SET_WRITE_LATCH_CMD: wel_next = 1'b1;
        CLEAR_WRITE_LATCH_CMD: begin
          if (!WIP_I) begin
            wel_next = 1'b0;
          end
        end
        STATUS_WRITE_CMD: begin
          if (wel_reg && !locked && cnt_reg >= SR_DATA_END_BITS) begin
            vol_next[IDX_SR1] = data_reg & SR1_STORED_MASK;
            nv_next[IDX_SR1] = data_reg & SR1_STORED_MASK;
          end
          wel_next = 1'b0;
        end
        GENERIC_REG_WRITE_CMD: begin
          if (wel_reg && !locked && cnt_reg >= ANY_DATA_END_BITS
              && bank_ok(addr_reg) && wr_idx <= IDX_CR5) begin
            vol_next[wr_idx] = (wr_idx == IDX_SR1) ? (data_reg & SR1_STORED_MASK) : data_reg;
            if (addr_reg[23:16] == NV_BANK) begin
              nv_next[wr_idx] = vol_next[wr_idx];
            end
          end
          wel_next = 1'b0;
        end
        default: ;
      endcase
    end
    if (!RST_B_I) begin
      vol_next = nv_reg;
      wel_next = 1'b0;
    end
    if (!POR_B_I) begin
      nv_next = NV_DEFAULTS;
      vol_next = NV_DEFAULTS;
      wel_next = 1'b0;
    end
  end
  always_ff @(posedge CLK_I) begin
    nv_reg <= nv_next;
    vol_reg <= vol_next;
    wel_reg <= wel_next;
  end
  assign SO_O = so_reg;
  assign SO_OE_B_O = oe_b_reg;
  assign WEL_O = wel_reg;
  assign SR1_O = {vol_reg[IDX_SR1][7:2], wel_reg, 1'b0};
  assign CR1_O = vol_reg[IDX_CR1];
  assign CR2_O = vol_reg[IDX_CR2];
  assign CR4_O = vol_reg[IDX_CR4];
  assign CR5_O = vol_reg[IDX_CR5];

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (rst_any);
  logic full_op;
  assign full_op = cs_rise && cnt_reg >= OPCODE_BITS;
  chk_set_latch: assert property (
    full_op && op_reg == SET_WRITE_LATCH_CMD |=> wel_reg && WEL_O)
    else $error("latch not set by set command");
  chk_clear_latch: assert property (
    full_op && op_reg == CLEAR_WRITE_LATCH_CMD && !WIP_I |=> !wel_reg)
    else $error("latch not cleared");
  chk_clear_busy: assert property (
    full_op && op_reg == CLEAR_WRITE_LATCH_CMD && WIP_I |=> $stable(wel_reg))
    else $error("clear honoured while busy");
  chk_short_frame: assert property (
    cs_rise && cnt_reg < OPCODE_BITS |=> $stable(wel_reg) && $stable(nv_reg))
    else $error("short frame changed state");
  chk_status_write_cmd_guard: assert property (
    full_op && op_reg == STATUS_WRITE_CMD && (!wel_reg || locked) |=> $stable(nv_reg))
    else $error("status write not refused");
  chk_status_write_cmd_store: assert property (
    full_op && op_reg == STATUS_WRITE_CMD && wel_reg && !locked
    && cnt_reg >= SR_DATA_END_BITS
    |=> nv_reg[IDX_SR1] == ($past(data_reg) & SR1_STORED_MASK) && !wel_reg)
    else $error("status write not stored");
  chk_generic_reg_write_cmd_lock: assert property (
    full_op && op_reg == GENERIC_REG_WRITE_CMD && locked
    |=> $stable(vol_reg) && !wel_reg)
    else $error("locked generic write took effect");
  chk_read_latency: assert property (
    state_reg == ST_SEND && $past(state_reg) != ST_SEND && op_reg != GENERIC_REG_READ_CMD
    |-> cnt_reg == OPCODE_BITS + LATENCY_BASE
      + {4'h0, vol_reg[IDX_CR5][REG_LATENCY_CODE_MSB_BIT:REG_LATENCY_CODE_LSB_BIT]})
    else $error("read started at wrong bit");
  chk_sr1_view: assert property (
    state_reg == ST_SEND && $past(state_reg) != ST_SEND && op_reg == STATUS_ONE_READ_CMD
    |-> out_reg[7:2] == vol_reg[IDX_SR1][7:2])
    else $error("status one read byte wrong");
  chk_reset_reload: assert property (
    @(posedge CLK_I) disable iff (!POR_B_I)
    !RST_B_I |=> vol_reg == $past(nv_reg) && !wel_reg)
    else $error("reset did not reload");

  cov_set_latch: cover property (full_op && op_reg == SET_WRITE_LATCH_CMD);
  cov_any_read: cover property (state_reg == ST_SEND && op_reg == GENERIC_REG_READ_CMD);
  cov_generic_reg_write_cmd_nv: cover property (full_op && op_reg == GENERIC_REG_WRITE_CMD && wel_reg
    && !locked && addr_reg[23:16] == NV_BANK);
endmodule

// [sim/spi_host_model.sv]
// Behavioural SPI host that drives opcode frames into the command logic
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic cs_b_o,
  output logic si_o
);
  initial begin
    sck_o = 1'b0;
    cs_b_o = 1'b1;
    si_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode 0 frame, MSB first, 80 ns serial clock that stands low between frames.
  // Read bits are sampled late in the high phase, because the output lags the fall.
  task automatic xfer(input logic [39:0] tx, input int nb, input int nr,
                      output logic [7:0] rx);
    rx = 8'h00;
    cs_b_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < nb + nr; i++) begin
      // Dummy and read phases toggle the data line so stale bits never look valid
      si_o <= (i < nb) ? tx[39 - i] : ~si_o;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      rx = {rx[6:0], so_i};
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_b_o <= 1'b1;
    si_o <= ~si_o;
    repeat (12) @(posedge clk_i);
  endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the write latch and register command logic
`timescale 1ns/1ps
module tb;
  import write_latch_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_b = 1'b0;
  logic wp_b = 1'b1;
  logic write_in_progress = 1'b0;
  logic crc_s = 1'b0;
  logic crc_a = 1'b0;
  logic sck, cs_b, si, so, so_oe_b, write_enable_latch;
  byte_t sr1, cr1, cr2, cr4, cr5;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  int lat = 0;
  logic [23:0] ga [4] = '{24'h000006, 24'h070002, 24'h000003, 24'h070005};
  byte_t gd [4] = '{8'h01, 8'h11, 8'h22, 8'h44};
  byte_t go [4] = '{CONFIG_FIVE_READ_CMD, CONFIG_ONE_READ_CMD, CONFIG_TWO_READ_CMD,
                    CONFIG_FOUR_READ_CMD};

  always #5 clk = ~clk;

  write_latch_cmd_ctrl i_write_latch_cmd_ctrl (
    .CLK_I(clk), .RST_B_I(rst_b), .POR_B_I(por_b), .SCK_I(sck), .CS_B_I(cs_b),
    .SI_I(si), .WP_B_I(wp_b), .WIP_I(write_in_progress), .CRC_SUSPEND_I(crc_s),
    .CRC_ABORT_I(crc_a), .SO_O(so), .SO_OE_B_O(so_oe_b), .WEL_O(write_enable_latch),
    .SR1_O(sr1), .CR1_O(cr1), .CR2_O(cr2), .CR4_O(cr4), .CR5_O(cr5)
  );

  // Released data line floats up to its pull-up level
  spi_host_model i_spi_host_model (
    .clk_i(clk), .so_i(so_oe_b ? 1'b1 : so), .sck_o(sck), .cs_b_o(cs_b), .si_o(si)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input byte_t seen, input byte_t exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmd(input logic [39:0] tx, input int nb);
    logic [7:0] rx;
    i_spi_host_model.xfer(tx, nb, 0, rx);
  endtask

  // Read frame: opcode or opcode plus address, then latency and one byte
  task automatic rd(input logic [39:0] tx, input int nb, input byte_t exp);
    logic [7:0] rx;
    i_spi_host_model.xfer(tx, nb, lat + 8, rx);
    chk(rx, exp);
    chk({7'h00, so_oe_b}, 8'h01);
  endtask

  task automatic set_write_latch_cmd();
    cmd({SET_WRITE_LATCH_CMD, 32'h0}, 8);
  endtask

  // Sized well above the longest test sequence
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    repeat (8) @(posedge clk);
    chk(sr1, 8'h00);
    chk(cr5, 8'h00);
    cmd({SET_WRITE_LATCH_CMD, 32'h0}, 5);
    chk({7'h00, write_enable_latch}, 8'h00);
    set_write_latch_cmd();
    chk(sr1, 8'h02);
    write_in_progress <= 1'b1;
    cmd({CLEAR_WRITE_LATCH_CMD, 32'h0}, 8);
    chk({7'h00, write_enable_latch}, 8'h01);
    write_in_progress <= 1'b0;
    // Last full opcode was a clear, so a short frame must not replay it
    cmd({CLEAR_WRITE_LATCH_CMD, 32'h0}, 5);
    chk({7'h00, write_enable_latch}, 8'h01);
    cmd({CLEAR_WRITE_LATCH_CMD, 32'h0}, 8);
    chk({7'h00, write_enable_latch}, 8'h00);
    $display("test latch done");

    cmd({STATUS_WRITE_CMD, 8'h8c, 24'h0}, 16);
    chk(sr1, 8'h00);
    set_write_latch_cmd();
    cmd({STATUS_WRITE_CMD, 8'h8c, 24'h0}, 16);
    chk(sr1, 8'h8c);
    rd({STATUS_ONE_READ_CMD, 32'h0}, 8, 8'h8c);
    write_in_progress <= 1'b1;
    rd({STATUS_ONE_READ_CMD, 32'h0}, 8, 8'h8d);
    write_in_progress <= 1'b0;
    $display("test status write done");

    wp_b <= 1'b0;
    set_write_latch_cmd();
    cmd({STATUS_WRITE_CMD, 8'h00, 24'h0}, 16);
    chk(sr1, 8'h8c);
    set_write_latch_cmd();
    cmd({GENERIC_REG_WRITE_CMD, 24'h000006, 8'h03}, 40);
    chk(cr5, 8'h00);
    chk({7'h00, write_enable_latch}, 8'h00);
    wp_b <= 1'b1;
    $display("test lock done");

    for (int i = 0; i < 4; i++) begin
      set_write_latch_cmd();
      cmd({GENERIC_REG_WRITE_CMD, ga[i], gd[i]}, 40);
      chk({7'h00, write_enable_latch}, 8'h00);
      lat = 1;
      rd({go[i], 32'h0}, 8, gd[i]);
    end
    chk(cr1, 8'h11);
    rd({GENERIC_REG_READ_CMD, 24'h000002, 8'h0}, 32, 8'h11);
    $display("test generic access done");

    crc_s <= 1'b1;
    rd({STATUS_TWO_READ_CMD, 32'h0}, 8, 8'h01);
    crc_s <= 1'b0;
    crc_a <= 1'b1;
    set_write_latch_cmd();
    cmd({GENERIC_REG_WRITE_CMD, 24'h070001, 8'hff}, 40);
    rd({STATUS_TWO_READ_CMD, 32'h0}, 8, 8'h02);
    $display("test status two done");

    set_write_latch_cmd();
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    chk(sr1, 8'h8c);
    chk(cr1, 8'h00);
    chk(cr2, 8'h22);
    chk(cr5, 8'h01);
    chk(cr4, 8'h00);
    // Config four was written to the live bank only, so reset drops it
    rd({CONFIG_FOUR_READ_CMD, 32'h0}, 8, 8'h00);
    $display("test reset done");
    stop_test();
  end
endmodule
